/* File: cdr_lock_monitor_power_ctl_tb_top.sv */
`timescale 1ns/1ns
`include "clmpc_defines.svh"
// Self-checking bench for registers, lock filter and power-down.
module cdr_lock_monitor_power_ctl_tb_top;
	import clmpc_pkg::*;
	localparam int unsigned PD = 20;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic sd = 1, pcd = 0, lcs = 0, lco = 0;
	logic [3:0] ws = 4'hf;
	clmpc_addr_type awa = 0, ara = 0;
	clmpc_word_type wd = 0, rdw, rdat, v;
	logic [15:0] pc = 0;
	logic [1:0] bresp, rresp, rs;
	logic awr, wrdy, bv, arr, rv, lk, pd, irq;
	logic [31:0] seed = 32'h7c3a_3983;
	int fail_count = 0, n_compared = 0, n;
	clmpc_top #(.PD_CYCLES(PD)) i_dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdw), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .signal_detect(sd), .ppm_count_done(pcd),
		.ppm_count(pc), .lock_check_strobe(lcs), .lock_check_ok(lco),
		.cdr_locked(lk), .channel_power_down(pd), .irq(irq)
	);
	// Free-running bus clock.
	initial forever #4 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	// Next value of the repeatable random stream.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected control register word.
	function automatic clmpc_word_type ctl_exp(logic r, logic l,
		logic [1:0] c);
		return 32'({r, l, c, 4'hf});
	endfunction
	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One register write; address and data released as each is taken.
	task automatic wr(input clmpc_addr_type a, input clmpc_word_type d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		do
		begin
			@(posedge aclk);
			if (awv && awr) awv <= 0;
			if (wv && wrdy) wv <= 0;
		end
		while (bv !== 1'b1);
		rs = bresp;
		br <= 0;
	endtask
	// One register read.
	task automatic rd(input clmpc_addr_type a);
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rr <= 1;
		do
		begin
			@(posedge aclk);
			if (arv && arr) arv <= 0;
		end
		while (rv !== 1'b1);
		rdat = rdw;
		rs = rresp;
		rr <= 0;
	endtask
	// One lock evaluation; the result line is flipped once released.
	task automatic lchk(input logic ok);
		@(posedge aclk);
		lcs <= 1;
		lco <= ok;
		@(posedge aclk);
		lcs <= 0;
		lco <= ~ok;
		repeat (2) @(posedge aclk);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Cuts a hang short.
	initial
	begin
		repeat (4000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end
	// Main sequence of tests.
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rd(`CLMPC_ADDR_CTL);
		chk(rdat, ctl_exp(0, 0, 3));
		rd(`CLMPC_ADDR_EYE);
		chk(rdat, 32'h0000_0088);
		rd(8'h50);
		chk(rdat, 32'h0000_0000);
		chk(rs, 2'b10);
		wr(8'h50, 32'h0000_00ff);
		chk(rs, 2'b10);
		$display("reset values done");
		v = xs();
		pc <= v[15:0];
		pcd <= 1;
		@(posedge aclk);
		pcd <= 0;
		pc <= ~v[15:0];
		rd(`CLMPC_ADDR_CTL);
		chk(rdat, ctl_exp(1, 0, 3));
		rd(`CLMPC_ADDR_COUNT);
		chk(rdat, {16'h0000, v[15:0]});
		wr(`CLMPC_ADDR_MASK, 32'h0000_0001);
		chk(rs, 2'b00);
		repeat (2) @(posedge aclk);
		chk(irq, 1);
		wr(`CLMPC_ADDR_STAT, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		wr(`CLMPC_ADDR_CTL, ctl_exp(0, 0, 3));
		rd(`CLMPC_ADDR_CTL);
		chk(rdat, ctl_exp(0, 0, 3));
		$display("ppm ready done");
		for (n = 0; n < 4; n++)
		begin
			wr(`CLMPC_ADDR_CTL, ctl_exp(0, 0, 2'(n)));
			lchk(1);
			chk(lk, 1);
			repeat (n) lchk(0);
			lchk(1);
			chk(lk, 1);
			repeat (n) lchk(0);
			chk(lk, 1);
			lchk(0);
			chk(lk, 0);
			rd(`CLMPC_ADDR_STAT);
			chk(rdat[1], 1);
			wr(`CLMPC_ADDR_STAT, 32'h0000_0002);
		end
		$display("lock filter done");
		sd <= 0;
		// Timer sees the low level from the next edge and ends PD edges on.
		repeat (PD) @(posedge aclk);
		chk(pd, 0);
		@(posedge aclk);
		chk(pd, 1);
		rd(`CLMPC_ADDR_STAT);
		chk(rdat[2], 1);
		sd <= 1;
		repeat (3) @(posedge aclk);
		chk(pd, 0);
		wr(`CLMPC_ADDR_CTL, ctl_exp(0, 1, 3));
		sd <= 0;
		repeat (PD + 10) @(posedge aclk);
		chk(pd, 0);
		sd <= 1;
		v = xs();
		wr(`CLMPC_ADDR_EYE, {24'h00_0000, v[7:0]});
		rd(`CLMPC_ADDR_EYE);
		chk(rdat, {24'h00_0000, v[7:0]});
		// A write whose low byte lane is off must leave the register alone.
		ws <= 4'he;
		wr(`CLMPC_ADDR_EYE, ~v);
		ws <= 4'hf;
		rd(`CLMPC_ADDR_EYE);
		chk(rdat, {24'h00_0000, v[7:0]});
		$display("power-down done");
		end_of_test();
	end
endmodule

/* File: clmpc_defines.svh */
`ifndef CLMPC_DEFINES_SVH
`define CLMPC_DEFINES_SVH

// Register indices; each register owns one aligned word, so its byte
// address is the index times four.
`define CLMPC_IDX_CTL 6'h34
`define CLMPC_IDX_EYE 6'h33
`define CLMPC_IDX_STAT 6'h10
`define CLMPC_IDX_MASK 6'h11
`define CLMPC_IDX_COUNT 6'h12
// Register byte addresses.
`define CLMPC_ADDR_CTL {`CLMPC_IDX_CTL, 2'b00}
`define CLMPC_ADDR_EYE {`CLMPC_IDX_EYE, 2'b00}
`define CLMPC_ADDR_STAT {`CLMPC_IDX_STAT, 2'b00}
`define CLMPC_ADDR_MASK {`CLMPC_IDX_MASK, 2'b00}
`define CLMPC_ADDR_COUNT {`CLMPC_IDX_COUNT, 2'b00}
// Field positions in the control register.
`define CLMPC_CTL_RDY 7
`define CLMPC_CTL_LPDIS 6
`define CLMPC_CTL_CNT_HI 5
`define CLMPC_CTL_CNT_LO 4
// Reset values.
`define CLMPC_CTL_RESET 8'h3f
`define CLMPC_EYE_RESET 8'h88
// Status bits: ppm ready, lock lost, powered down.
`define CLMPC_ST_PPM 0
`define CLMPC_ST_LOSS 1
`define CLMPC_ST_PD 2
`define CLMPC_ST_W 3
// Power-down delay in ms and its cycle count at 125 MHz.
`define CLMPC_PD_DELAY_MS 100
`define CLMPC_CLK_KHZ 125000
`define CLMPC_PD_CYCLES (`CLMPC_PD_DELAY_MS * `CLMPC_CLK_KHZ)
// Bus responses.
`define CLMPC_RESP_OKAY 2'b00
`define CLMPC_RESP_SLVERR 2'b10

`endif

/* File: clmpc_lock_filter.sv */
`timescale 1ns/1ns
`include "clmpc_defines.svh"
// Lock-loss filter: repeats failing lock checks before declaring loss.
module clmpc_lock_filter
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic check_strobe,
	input wire logic lock_ok,
	input wire logic [1:0] retries,
	output logic locked,
	output logic lost_pulse
);
	import clmpc_pkg::*;

	clmpc_lock_type state_q;
	logic [1:0] fail_q;

	// One evaluation per check strobe.
	always_ff @(posedge aclk)
	begin
		lost_pulse <= 1'b0;
		if (!aresetn)
		begin
			state_q <= CLMPC_UNLOCKED;
			fail_q <= 2'h0;
			locked <= 1'b0;
		end
		else if (check_strobe)
		begin
			case (state_q)
				CLMPC_UNLOCKED:
				begin
					if (lock_ok)
					begin
						state_q <= CLMPC_LOCKED;
						locked <= 1'b1;
					end
				end
				CLMPC_LOCKED:
				begin
					if (!lock_ok && retries == 2'h0)
					begin
						state_q <= CLMPC_UNLOCKED;
						locked <= 1'b0;
						lost_pulse <= 1'b1;
					end
					else if (!lock_ok)
					begin
						state_q <= CLMPC_RECHECK;
						fail_q <= 2'h1;
					end
				end
				CLMPC_RECHECK:
				begin
					if (lock_ok)
					begin
						state_q <= CLMPC_LOCKED;
						fail_q <= 2'h0;
					end
					else if (fail_q >= retries)
					begin
						state_q <= CLMPC_UNLOCKED;
						fail_q <= 2'h0;
						locked <= 1'b0;
						lost_pulse <= 1'b1;
					end
					else
						fail_q <= fail_q + 2'h1;
				end
				default:
				begin
					state_q <= CLMPC_UNLOCKED;
					locked <= 1'b0;
				end
			endcase
		end
	end
endmodule

/* File: clmpc_pkg.sv */
package clmpc_pkg;
	typedef logic [31:0] clmpc_word_type;
	typedef logic [7:0] clmpc_addr_type;
	typedef enum logic [2:0]
	{
		CLMPC_UNLOCKED = 3'b001,
		CLMPC_LOCKED = 3'b010,
		CLMPC_RECHECK = 3'b100
	} clmpc_lock_type;
endpackage

/* File: clmpc_props.sv */
`timescale 1ns/1ns
// Port checks of power-down timing and lock-loss filtering.
module clmpc_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic signal_detect,
	input wire logic lock_check_strobe,
	input wire logic lock_check_ok,
	input wire logic cdr_locked,
	input wire logic channel_power_down
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Lock indication stays up for two cycles.
	sequence held_s;
		cdr_locked ##1 cdr_locked;
	endsequence
	chk_pd_after_loss: assert property (
		$rose(channel_power_down) |-> $past(!signal_detect, 1)
	) else $error("power-down without signal loss");
	chk_pd_wake_up: assert property (
		signal_detect |=> !channel_power_down
	) else $error("power-down while signal present");
	chk_loss_cause: assert property (
		$fell(cdr_locked) |-> $past(lock_check_strobe && !lock_check_ok, 2)
	) else $error("lock dropped without a failed check");
	chk_relock_hold: assert property (
		(lock_check_strobe && lock_check_ok && cdr_locked
		&& !$past(lock_check_strobe)) |=> held_s
	) else $error("lock dropped after a passing check");
	chk_lock_cause: assert property (
		$rose(cdr_locked) |-> $past(lock_check_strobe && lock_check_ok, 2)
	) else $error("lock raised without a passing check");
endmodule
bind clmpc_top clmpc_props i_props (.aclk, .aresetn, .signal_detect,
	.lock_check_strobe, .lock_check_ok, .cdr_locked, .channel_power_down);

/* File: clmpc_top.sv */
`timescale 1ns/1ns
`include "clmpc_defines.svh"
module clmpc_top
#(
	parameter int unsigned PD_CYCLES = `CLMPC_PD_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire clmpc_pkg::clmpc_addr_type s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire clmpc_pkg::clmpc_word_type s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire clmpc_pkg::clmpc_addr_type s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output clmpc_pkg::clmpc_word_type s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signal_detect,
	input wire logic ppm_count_done,
	input wire logic [15:0] ppm_count,
	input wire logic lock_check_strobe,
	input wire logic lock_check_ok,
	output logic cdr_locked,
	output logic channel_power_down,
	output logic irq
);
	import clmpc_pkg::*;

	logic [7:0] ctl_q;
	logic [7:0] eye_q;
	logic [15:0] count_q;
	logic [`CLMPC_ST_W-1:0] stat_q;
	logic [`CLMPC_ST_W-1:0] mask_q;
	logic [31:0] pd_cnt_q;
	logic aw_q;
	logic w_q;
	clmpc_addr_type awaddr_q;
	clmpc_word_type wdata_q;
	logic wstrb_q;
	logic wr_go;
	logic locked;
	logic lost_pulse;
	logic [`CLMPC_ST_W-1:0] events;
	logic [`CLMPC_ST_W-1:0] w1c;

	////////////////////////////////////////////////////////////////////
	// Builds the word read back at a given address.
	function automatic clmpc_word_type read_word(input clmpc_addr_type a);
		begin
			case (a)
				`CLMPC_ADDR_CTL: read_word = {24'h00_0000, ctl_q};
				`CLMPC_ADDR_EYE: read_word = {24'h00_0000, eye_q};
				`CLMPC_ADDR_STAT: read_word = {29'h0000_0000, stat_q};
				`CLMPC_ADDR_MASK: read_word = {29'h0000_0000, mask_q};
				`CLMPC_ADDR_COUNT: read_word = {16'h0000, count_q};
				default: read_word = 32'h0000_0000;
			endcase
		end
	endfunction

	// True for an address that decodes to a register.
	function automatic logic mapped(input clmpc_addr_type a);
		begin
			mapped = (a == `CLMPC_ADDR_CTL) || (a == `CLMPC_ADDR_EYE) ||
				(a == `CLMPC_ADDR_STAT) || (a == `CLMPC_ADDR_MASK) ||
				(a == `CLMPC_ADDR_COUNT);
		end
	endfunction

	// True once the power-down timer has reached its end count.
	function automatic logic pd_due(input logic [31:0] c);
		begin
			pd_due = (c >= PD_CYCLES - 1);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Write channel capture: address and data taken in either order.
	assign wr_go = aw_q && w_q && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CLMPC_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				// The strobe belongs to the data beat, so keep it with it.
				wstrb_q <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_q) ? `CLMPC_RESP_OKAY :
					`CLMPC_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one answer per taken address.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CLMPC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_word(s_axi_araddr);
				s_axi_rresp <= mapped(s_axi_araddr) ? `CLMPC_RESP_OKAY :
					`CLMPC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control, threshold and mask registers; the ready flag is hardware set.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_q <= `CLMPC_CTL_RESET;
			eye_q <= `CLMPC_EYE_RESET;
			mask_q <= '0;
		end
		else
		begin
			if (wr_go && wstrb_q)
			begin
				if (awaddr_q == `CLMPC_ADDR_CTL)
					ctl_q <= wdata_q[7:0];
				if (awaddr_q == `CLMPC_ADDR_EYE)
					eye_q <= wdata_q[7:0];
				if (awaddr_q == `CLMPC_ADDR_MASK)
					mask_q <= wdata_q[`CLMPC_ST_W-1:0];
			end
			if (ppm_count_done)
				ctl_q[`CLMPC_CTL_RDY] <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= 16'h0000;
		else if (ppm_count_done)
			count_q <= ppm_count;
	end

	////////////////////////////////////////////////////////////////////
	// Power-down timer runs while signal detect is low and the power-down disable bit is clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pd_cnt_q <= 32'h0000_0000;
			channel_power_down <= 1'b0;
		end
		else if (signal_detect || ctl_q[`CLMPC_CTL_LPDIS])
		begin
			pd_cnt_q <= 32'h0000_0000;
			channel_power_down <= 1'b0;
		end
		else if (pd_due(pd_cnt_q))
			channel_power_down <= 1'b1;
		else
			pd_cnt_q <= pd_cnt_q + 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////
	// Lock-loss filter with programmable retries.
	clmpc_lock_filter u_filter
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.check_strobe(lock_check_strobe),
		.lock_ok(lock_check_ok),
		.retries(ctl_q[`CLMPC_CTL_CNT_HI:`CLMPC_CTL_CNT_LO]),
		.locked(locked),
		.lost_pulse(lost_pulse)
	);

	// Lock output registered straight from the filter.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cdr_locked <= 1'b0;
		else
			cdr_locked <= locked;
	end

	////////////////////////////////////////////////////////////////////
	// Sticky status; a set in the clear cycle wins.
	always_comb
	begin
		events = '0;
		events[`CLMPC_ST_PPM] = ppm_count_done;
		events[`CLMPC_ST_LOSS] = lost_pulse;
		events[`CLMPC_ST_PD] = !signal_detect &&
			!ctl_q[`CLMPC_CTL_LPDIS] && pd_due(pd_cnt_q) &&
			!channel_power_down;
		w1c = '0;
		if (wr_go && wstrb_q && awaddr_q == `CLMPC_ADDR_STAT)
			w1c = wdata_q[`CLMPC_ST_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_q <= '0;
			irq <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~w1c) | events;
			irq <= |(((stat_q & ~w1c) | events) & mask_q);
		end
	end
endmodule
